// [core/epr_top.sv]
// Serial EEPROM instruction front end with whole-memory programming and status
// Overview of operation
// - Erase-all sets every memory bit to one; address is dummy.
// - Erase-type instruction starts its self-timed cycle on select falling.
// - Write-all programs the given byte or word into every address.
// - Opcode 00 with address top bits 10 erase-all, 01 write-all.
// - Programming cycle: output shows 0 busy, 1 ready while select high.
// - Serial input ignored while a programming cycle runs.
// - Ready level stays until new start bit or select low.
// - After select rises, first one sampled on a clock rise is start.
// - Enhanced variant counts clock pulses from start to select falling.
// - Byte organization: write runs only with exactly 20 pulses.
// - Word organization: write runs only with exactly 27 pulses.
// - Pulse check applies only to programming instructions.
// - Memory starts with all locations holding all ones.
// - Organization input high selects words, low selects bytes.
`timescale 1ns/1ps
module epr_top #(
	parameter int PROG_CYCLES_P = epr_pkg::PROG_CYCLES
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_resetn,
	// Serial pins
	input  wire logic i_select,
	input  wire logic i_sclk,
	input  wire logic i_din,
	output logic      o_dout,
	output logic      o_dout_oe,
	// Straps
	input  wire logic i_org,
	input  wire logic i_enhanced
);
	import epr_pkg::*;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_HUNT,
		ST_FRAME
	} epr_state_t;

	epr_prog_if prog ();

	epr_engine #(
		.PROG_CYCLES_P (PROG_CYCLES_P)
	) u_engine (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.prog     (prog)
	);

	// Two-stage synchronisers for the serial and strap inputs (select, clock, data in, org, enhanced)
	logic [4:0]             sync1;
	logic [4:0]             sync2;
	logic                   sclk_prev;
	logic                   sel_prev;
	epr_state_t             state;
	epr_state_t             next_state;
	logic [FRAME_W-1:0]     frame;
	logic [FRAME_W-1:0]     next_frame;
	logic [CNT_W-1:0]       count;
	logic [CNT_W-1:0]       next_count;
	logic                   armed;
	logic                   next_armed;
	logic                   start;
	logic                   next_start;
	epr_prog_t              op;
	epr_prog_t              next_op;
	logic [7:0]             addr;
	logic [7:0]             next_addr;
	logic [15:0]            data;
	logic [15:0]            next_data;
	logic                   word;
	logic                   next_word;
	logic                   dout;
	logic                   next_dout;
	logic                   dout_oe;
	logic                   next_dout_oe;

	logic sel_s;
	logic sclk_s;
	logic din_s;
	logic org_s;
	logic enh_s;
	logic sclk_rise;
	logic sel_fall;

	assign sel_s     = sync2[0];
	assign sclk_s    = sync2[1];
	assign din_s     = sync2[2];
	assign org_s     = sync2[3];
	assign enh_s     = sync2[4];
	assign sclk_rise = sclk_s && !sclk_prev;
	assign sel_fall  = sel_prev && !sel_s;

	assign prog.start = start;
	assign prog.op    = op;
	assign prog.addr  = addr;
	assign prog.data  = data;
	assign prog.word  = word;
	assign o_dout     = dout;
	assign o_dout_oe  = dout_oe;

	// Decode of a finished frame; valid marks a programming instruction
	function automatic logic decode(input logic [FRAME_W-1:0] f, input logic w,
	                                output epr_prog_t kind, output logic has_data);
		decode   = 1'b1;
		has_data = 1'b0;
		kind     = PRG_WRITE;
		if (f[25:24] == OPC_WRITE) begin
			has_data = 1'b1;
		end else if (f[25:24] == OPC_ERASE) begin
			kind = PRG_ERASE;
		end else if (f[25:24] == OPC_MISC && f[23:22] == SUB_ERASE_ALL) begin
			kind = PRG_ERASE_ALL;
		end else if (f[25:24] == OPC_MISC && f[23:22] == SUB_PROG_ALL) begin
			kind     = PRG_PROGRAM_ALL;
			has_data = 1'b1;
		end else begin
			decode = 1'b0;
		end
		if (w == 1'b0 && kind == PRG_ERASE && f[25:24] != OPC_ERASE) begin
			decode = 1'b0;
		end
	endfunction : decode

	always_comb begin
		logic             ok;
		logic             has_data;
		epr_prog_t        kind;
		logic [CNT_W-1:0] want;
		ok           = 1'b0;
		has_data     = 1'b0;
		kind         = PRG_WRITE;
		want         = CNT_ZERO;
		next_state   = state;
		next_frame   = frame;
		next_count   = count;
		next_start   = 1'b0;
		next_op      = op;
		next_addr    = addr;
		next_data    = data;
		next_word    = word;
		next_armed   = armed;
		case (state)
			ST_OFF: begin
				if (sel_s) begin
					next_state = ST_HUNT;
				end
			end
			ST_HUNT: begin
				if (!sel_s) begin
					next_state = ST_OFF;
				end else if (sclk_rise && din_s && !prog.busy) begin
					next_state = ST_FRAME;
					next_count = CNT_ONE;
					next_frame = '0;
				end
			end
			ST_FRAME: begin
				if (sel_s && sclk_rise) begin
					if (count != CNT_MAX) begin
						next_count = count + CNT_ONE;
					end
					if (count <= CNT_W'(FRAME_W)) begin
						next_frame[CNT_W'(FRAME_W) - count] = din_s;
					end
				end
				if (sel_fall) begin
					next_state = ST_OFF;
					ok = decode(frame, org_s, kind, has_data);
					if (has_data) begin
						want = org_s ? LEN_WRITE_WORD : LEN_WRITE_BYTE;
					end else begin
						want = org_s ? LEN_ERASE_WORD : LEN_ERASE_BYTE;
					end
					// exact count check; base skips it
					if (enh_s && count != want) begin
						ok = 1'b0;
					end
					if (ok && !prog.busy) begin
						next_start = 1'b1;
						next_armed = 1'b1;
						next_op    = kind;
						next_word  = org_s;
						if (org_s) begin
							next_addr = {frame[22:16], 1'b0};
							next_data = frame[15:0];
						end else begin
							next_addr = frame[22:15];
							next_data = {8'h00, frame[14:7]};
						end
					end
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		// ready held until select low or new start
		if (!next_start && !prog.busy && !start &&
		    (!sel_s || (state == ST_HUNT && next_state == ST_FRAME))) begin
			next_armed = 1'b0;
		end
		// status on output while select high
		next_dout_oe = next_armed && sel_s;
		next_dout    = next_armed && sel_s && !prog.busy && !start;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1     <= 5'h00;
			sync2     <= 5'h00;
			sclk_prev <= 1'b0;
			sel_prev  <= 1'b0;
			state     <= ST_OFF;
			frame     <= '0;
			count     <= CNT_ZERO;
			start     <= 1'b0;
			op        <= PRG_WRITE;
			addr      <= 8'h00;
			data      <= 16'h0000;
			word      <= 1'b0;
			armed     <= 1'b0;
			dout      <= 1'b0;
			dout_oe   <= 1'b0;
		end else begin
			sync1     <= {i_enhanced, i_org, i_din, i_sclk, i_select};
			sync2     <= sync1;
			sclk_prev <= sclk_s;
			sel_prev  <= sel_s;
			state     <= next_state;
			frame     <= next_frame;
			count     <= next_count;
			start     <= next_start;
			op        <= next_op;
			addr      <= next_addr;
			data      <= next_data;
			word      <= next_word;
			armed     <= next_armed;
			dout      <= next_dout;
			dout_oe   <= next_dout_oe;
		end
	end
endmodule : epr_top

// [core/epr_pkg.sv]
// Shared constants and types of the serial EEPROM programming block
package epr_pkg;
	// Timing
	localparam int CLK_FREQ_KHZ = 25000;
	localparam int PROG_TIME_US = 10000;
	localparam int PROG_CYCLES  = PROG_TIME_US * (CLK_FREQ_KHZ / 1000);
	// Frame layout
	localparam int FRAME_W   = 26;
	localparam int CNT_W     = 5;
	localparam int BYTES     = 256;
	localparam int HDR_LEN   = 3;
	localparam int ADDR_WORD = 8;
	localparam int ADDR_BYTE = 9;
	localparam int DATA_WORD = 16;
	localparam int DATA_BYTE = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
	localparam logic [CNT_W-1:0] CNT_MAX  = 5'h1f;
	localparam logic [CNT_W-1:0] LEN_ERASE_WORD = CNT_W'(HDR_LEN + ADDR_WORD);
	localparam logic [CNT_W-1:0] LEN_ERASE_BYTE = CNT_W'(HDR_LEN + ADDR_BYTE);
	localparam logic [CNT_W-1:0] LEN_WRITE_WORD = CNT_W'(HDR_LEN + ADDR_WORD + DATA_WORD);
	localparam logic [CNT_W-1:0] LEN_WRITE_BYTE = CNT_W'(HDR_LEN + ADDR_BYTE + DATA_BYTE);
	// Instruction codes
	localparam logic [1:0] OPC_MISC     = 2'h0;
	localparam logic [1:0] OPC_WRITE    = 2'h1;
	localparam logic [1:0] OPC_ERASE    = 2'h3;
	localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
	localparam logic [1:0] SUB_PROG_ALL  = 2'h1;
	localparam logic [7:0] BYTE_ERASED  = 8'hff;
	typedef enum logic [1:0] {
		PRG_WRITE,
		PRG_ERASE,
		PRG_ERASE_ALL,
		PRG_PROGRAM_ALL
	} epr_prog_t;
endpackage : epr_pkg

// [core/epr_prog_if.sv]
// Request and status between instruction front end and programming engine
`timescale 1ns/1ps
interface epr_prog_if;
	import epr_pkg::*;
	logic        start;
	epr_prog_t   op;
	logic [7:0]  addr;
	logic [15:0] data;
	logic        word;
	logic        busy;
	modport front (output start, output op, output addr, output data, output word, input busy);
	modport engine (input start, input op, input addr, input data, input word, output busy);
endinterface : epr_prog_if

// [core/epr_engine.sv]
// Self-timed programming engine with the memory array
`timescale 1ns/1ps
module epr_engine #(
	parameter int PROG_CYCLES_P = epr_pkg::PROG_CYCLES
) (
	// Clock and reset
	input  wire logic  i_clock,
	input  wire logic  i_resetn,
	// Request
	epr_prog_if.engine prog
);
	import epr_pkg::*;
	localparam int TW = $clog2(PROG_CYCLES_P + 1);

	logic [7:0]    mem [BYTES];
	logic [7:0]    next_mem [BYTES];
	logic [TW-1:0] timer;
	logic [TW-1:0] next_timer;
	logic          busy;
	logic          next_busy;
	epr_prog_t     op;
	epr_prog_t     next_op;
	logic [7:0]    addr;
	logic [7:0]    next_addr;
	logic [15:0]   data;
	logic [15:0]   next_data;
	logic          word;
	logic          next_word;

	assign prog.busy = busy;

	always_comb begin
		next_timer = timer;
		next_busy  = busy;
		next_op    = op;
		next_addr  = addr;
		next_data  = data;
		next_word  = word;
		for (int i = 0; i < BYTES; i++) begin
			next_mem[i] = mem[i];
		end
		if (prog.start && !busy) begin
			next_busy  = 1'b1;
			next_timer = TW'(PROG_CYCLES_P);
			next_op    = prog.op;
			next_addr  = prog.addr;
			next_data  = prog.data;
			next_word  = prog.word;
		end else if (busy) begin
			next_timer = timer - TW'(1);
			if (timer == TW'(1)) begin
				next_busy = 1'b0;
				case (op)
					PRG_WRITE: begin
						if (word) begin
							next_mem[addr]      = data[15:8];
							next_mem[addr | 8'h01] = data[7:0];
						end else begin
							next_mem[addr] = data[7:0];
						end
					end
					PRG_ERASE: begin
						next_mem[addr] = BYTE_ERASED;
						if (word) begin
							next_mem[addr | 8'h01] = BYTE_ERASED;
						end
					end
					PRG_ERASE_ALL: begin
						for (int i = 0; i < BYTES; i++) begin
							next_mem[i] = BYTE_ERASED;
						end
					end
					PRG_PROGRAM_ALL: begin
						for (int i = 0; i < BYTES; i++) begin
							next_mem[i] = word ? ((i % 2 == 0) ? data[15:8] : data[7:0])
							                   : data[7:0];
						end
					end
					default: begin
						next_busy = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			timer <= '0;
			busy  <= 1'b0;
			op    <= PRG_WRITE;
			addr  <= 8'h00;
			data  <= 16'h0000;
			word  <= 1'b0;
			for (int i = 0; i < BYTES; i++) begin
				mem[i] <= BYTE_ERASED;
			end
		end else begin
			timer <= next_timer;
			busy  <= next_busy;
			op    <= next_op;
			addr  <= next_addr;
			data  <= next_data;
			word  <= next_word;
			for (int i = 0; i < BYTES; i++) begin
				mem[i] <= next_mem[i];
			end
		end
	end
endmodule : epr_engine

// [core/epr_dummy_unused.sv]
// Empty file; the block's logic lives in the other core files

// [dv/epr_top_assertions.sv]
// Pin-level checks of the programming status output
`timescale 1ns/1ps
module epr_top_assertions #(
	parameter int PROG_CYCLES_P = 400
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_select,
	input wire logic i_sclk,
	input wire logic i_din,
	input wire logic o_dout,
	input wire logic o_dout_oe,
	input wire logic i_org,
	input wire logic i_enhanced
);
	logic sel_q;
	int   since_fall;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// Age of the select fall that ended the last frame
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_q      <= 1'b0;
			since_fall <= 0;
		end else begin
			sel_q      <= i_select;
			since_fall <= (sel_q && !i_select && !o_dout_oe) ? 0 : since_fall + 1;
		end
	end
	a_oe_drops_unsel: assert property (
		$fell(i_select) |-> ##[1:6] !o_dout_oe) else $error("status kept after select low");
	a_oe_off_idle: assert property (
		(!i_select)[*6] |-> !o_dout_oe) else $error("status driven while unselected");
	a_oe_needs_sel: assert property (
		$rose(o_dout_oe) |-> $past(i_select, 3)) else $error("status without select");
	a_ready_holds: assert property (
		(o_dout_oe && o_dout && !i_din)[*4] ##1 o_dout_oe |-> o_dout) else $error("ready lost");
	a_busy_min_time: assert property (
		o_dout_oe && o_dout && $past(o_dout_oe) && !$past(o_dout) |->
		since_fall >= PROG_CYCLES_P) else $error("cycle ended early");
	a_busy_max_time: assert property (
		o_dout_oe && !o_dout |-> since_fall <= PROG_CYCLES_P + 12) else $error("busy too long");
	a_ready_late: assert property (
		o_dout_oe && o_dout |-> since_fall >= PROG_CYCLES_P) else $error("ready too soon");
	a_no_busy_again: assert property (
		$fell(o_dout) |-> !o_dout_oe) else $error("ready fell back to busy");
	c_busy: cover property (o_dout_oe && !o_dout);
	c_ready: cover property (o_dout_oe && $rose(o_dout));
	c_oe_up: cover property ($rose(o_dout_oe));
endmodule : epr_top_assertions

// [dv/epr_host.sv]
// Host model driving select, serial clock and data in
`timescale 1ns/1ps
module epr_host (
	// Clock
	input  wire logic i_clock,
	// Serial pins
	output logic      o_select,
	output logic      o_sclk,
	output logic      o_din,
	input  wire logic i_dout,
	input  wire logic i_dout_oe
);
	initial begin
		o_select = 1'b0;
		o_sclk   = 1'b0;
		o_din    = 1'b1;
	end
	task automatic ticks(input int n);
		repeat (n) @(posedge i_clock);
	endtask : ticks
	// select with clock low, start bit, fields, n pulses
	task automatic send(input logic [27:0] bits, input int n);
		o_select <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			ticks(4);
			o_sclk <= 1'b0;
			o_din  <= bits[i];
			ticks(4);
			o_sclk <= 1'b1;
		end
		ticks(4);
		o_sclk <= 1'b0;
		ticks(4);
		o_select <= 1'b0;
		o_din    <= ~o_din;
		ticks(8);
	endtask : send
	task automatic status(input int lim, output int cyc, output logic seen);
		seen = 1'b0;
		cyc  = 0;
		o_select <= 1'b1;
		o_din    <= 1'b0;
		while (cyc < lim && !(i_dout_oe === 1'b1 && i_dout === 1'b1)) begin
			ticks(1);
			#1;
			cyc++;
			if (i_dout_oe === 1'b1 && i_dout === 1'b0)
				seen = 1'b1;
		end
		// Hold select so the ready level is seen standing
		ticks(4);
		o_select <= 1'b0;
		ticks(8);
	endtask : status
endmodule : epr_host

// [dv/epr_top_bench.sv]
// Self-checking bench of the whole-memory programming block
`timescale 1ns/1ps
module epr_top_bench;
	import epr_pkg::*;
	localparam int PROG = 400;
	logic clock;
	logic resetn;
	logic org;
	logic enh;
	logic select;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe;
	int   fail_count;
	int   comparisons;
	int   cycles;
	epr_top #(.PROG_CYCLES_P(PROG)) epr_top_i (.i_clock(clock), .i_resetn(resetn),
		.i_select(select), .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
		.i_org(org), .i_enhanced(enh));
	epr_host epr_host_i (.i_clock(clock), .o_select(select), .o_sclk(sclk), .o_din(din),
		.i_dout(dout), .i_dout_oe(dout_oe));
	always #20 clock = ~clock;
	task automatic test_done;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic check_mem(input logic [7:0] hi, input logic [7:0] lo);
		for (int a = 0; a < BYTES; a++)
			chk(epr_top_i.u_engine.mem[a], a[0] ? lo : hi);
	endtask : check_mem
	task automatic wait_ready;
		int   cyc;
		logic seen;
		epr_host_i.status(PROG + 40, cyc, seen);
		chk(seen, 1'b1);
		chk(cyc < PROG + 40, 1'b1);
	endtask : wait_ready
	task automatic t_prog_all_word;
		epr_host_i.send({1'b1, 2'h0, 8'h40, 16'h1234}, 27);
		epr_host_i.send({1'b1, 2'h0, 8'h40, 16'h0000}, 27);
		wait_ready();
		check_mem(8'h12, 8'h34);
		epr_host_i.send({1'b1, 2'h0, 8'h40, 16'h0000, 1'b0}, 28);
		epr_host_i.ticks(PROG + 40);
		check_mem(8'h12, 8'h34);
		$display("test prog_all_word done");
	endtask : t_prog_all_word
	task automatic t_erase_all;
		epr_host_i.send({1'b1, 2'h0, 8'h80}, 11);
		wait_ready();
		check_mem(8'hff, 8'hff);
		$display("test erase_all done");
	endtask : t_erase_all
	task automatic t_byte_mode;
		org <= 1'b0;
		epr_host_i.ticks(4);
		epr_host_i.send({1'b1, 2'h0, 9'h080, 8'h5a}, 20);
		wait_ready();
		check_mem(8'h5a, 8'h5a);
		epr_host_i.send({1'b1, 2'h0, 9'h080, 7'h00}, 19);
		epr_host_i.ticks(PROG + 40);
		check_mem(8'h5a, 8'h5a);
		$display("test byte_mode done");
	endtask : t_byte_mode
	task automatic t_base_variant;
		enh <= 1'b0;
		epr_host_i.ticks(4);
		epr_host_i.send({1'b1, 2'h0, 9'h100, 1'b0}, 13);
		wait_ready();
		check_mem(8'hff, 8'hff);
		$display("test base_variant done");
	endtask : t_base_variant
	task automatic t_single_ops;
		org <= 1'b1;
		enh <= 1'b1;
		epr_host_i.ticks(4);
		epr_host_i.send({1'b1, 2'h1, 8'h05, 16'hbeef}, 27);
		wait_ready();
		chk(epr_top_i.u_engine.mem[10], 8'hbe);
		chk(epr_top_i.u_engine.mem[11], 8'hef);
		chk(epr_top_i.u_engine.mem[12], 8'hff);
		epr_host_i.send({1'b1, 2'h3, 8'h05}, 11);
		wait_ready();
		chk(epr_top_i.u_engine.mem[10], 8'hff);
		chk(epr_top_i.u_engine.mem[11], 8'hff);
		epr_host_i.send({1'b1, 2'h1, 8'h05, 15'h0000}, 26);
		epr_host_i.ticks(PROG + 40);
		chk(epr_top_i.u_engine.mem[10], 8'hff);
		$display("test single_ops done");
	endtask : t_single_ops
	initial begin
		clock  = 1'b0;
		resetn = 1'b0;
		org    = 1'b1;
		enh    = 1'b1;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		check_mem(8'hff, 8'hff);
		t_prog_all_word();
		t_erase_all();
		t_byte_mode();
		t_base_variant();
		t_single_ops();
		test_done();
	end
endmodule : epr_top_bench
bind epr_top epr_top_assertions #(.PROG_CYCLES_P(PROG_CYCLES_P)) epr_top_assertions_i (
	.i_clock(i_clock), .i_resetn(i_resetn), .i_select(i_select), .i_sclk(i_sclk),
	.i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .i_org(i_org),
	.i_enhanced(i_enhanced));
